/* verilog/gpps_pkg.sv */
// Package with register map, field layout and carrier types of the port block
`default_nettype none
package gpps_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_DIR = 8'h00;
    localparam logic [7:0] OFS_LEVEL = 8'h04;
    localparam logic [7:0] OFS_LATCH = 8'h08;
    localparam logic [7:0] OFS_ANSEL = 8'h0C;
    localparam logic [7:0] OFS_ALT = 8'h10;
    // Implemented bits of all registers but level, and the direction bit fixed at one
    localparam logic [5:0] DIR_MASK = 6'h37;
    localparam logic [5:0] DIR_FIXED = 6'h08;
    localparam logic [5:0] LAT_MASK = 6'h37;
    localparam logic [5:0] ANS_MASK = 6'h17;
    localparam logic [7:0] ALT_MASK = 8'h3B;
    // Reset values
    localparam logic [5:0] DIR_RST = 6'h3F;
    localparam logic [5:0] LAT_RST = 6'h00;
    localparam logic [5:0] ANS_RST = 6'h17;
    localparam logic [7:0] ALT_RST = 8'h00;
    // Field positions in the alternate select register
    localparam int ALT_SDO = 5;
    localparam int ALT_SS = 4;
    localparam int ALT_GATE = 3;
    localparam int ALT_CLC = 1;
    localparam int ALT_NCO = 0;
    // Pin positions
    localparam int PIN_1 = 1;
    localparam int PIN_2 = 2;
    localparam int PIN_3 = 3;
    localparam int PIN_4 = 4;
    localparam int PIN_5 = 5;

    // Peripheral outputs that may take over a pin
    typedef struct packed {
        logic sdoOut;
        logic sdoEn;
        logic clcOut;
        logic clcEn;
        logic ncoOut;
        logic ncoEn;
    } gpps_periph_type;

    // Peripheral inputs fed from the pins
    typedef struct packed {
        logic slaveSel;
        logic timerGate;
    } gpps_route_in_type;

    // APB answer
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } gpps_apb_rsp_type;

    // Whole state of the block
    typedef struct packed {
        logic [5:0] dir;
        logic [5:0] lat;
        logic [5:0] ansel;
        logic [7:0] alt;
        gpps_apb_rsp_type rsp;
        logic [5:0] padOut;
        logic [5:0] padOe;
        logic [5:0] pcOut;
        logic [5:0] pcOvr;
        gpps_route_in_type routed;
    } gpps_state_type;
endpackage
`default_nettype wire

/* verilog/gpps_port.sv */
// Six-bit general purpose port with analog select and peripheral pin steering
//
// Summary of operation
// - Latch write equals pin-level register write
// - Latch reads latch; level reads pins
// - Analog select disables digital input buffer
// - Enabled peripheral blocks general output, readable
// - Steering forces the pin driver on; overrides follow selection
// - Bit 5: serial out on a4/c2
// - Bit 4: slave select from a3/c3
// - Bit 3: timer gate from a3/a4
// - Bit 1: logic cell on c5/a2
// - Bit 0: oscillator output on a4/c1
// - Select bits 7,6,2 read zero
// - Six pins each with level; all but a3 with direction, latch
// - Direction 1 input, 0 drives latch
// - Pin a3 input only, direction reads one
// - Level write samples pins, merges, latches
// - Direction still gates driver on analog pins
// - Analog pins read zero digitally
// - Analog select never affects digital output
// - Analog select resets to analog
//
// The register addresses and the APB slave port were decided locally.
`default_nettype none
module gpps_port
    import gpps_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port A pads
    input wire logic [5:0] padIn,
    output logic [5:0] padOut,
    output logic [5:0] padOe,
    // Port C pads shared with steered functions
    input wire logic [5:0] pcIn,
    output logic [5:0] pcOut,
    output logic [5:0] pcOvr,
    // Peripheral side
    input wire gpps_periph_type periph,
    output gpps_route_in_type routed
);

    // Masked write of one register byte
    function automatic logic [7:0] wrMask(
        input logic [7:0] old,
        input logic [7:0] val,
        input logic [7:0] mask
    );
        wrMask = (old & ~mask) | (val & mask);
    endfunction

    // Register selection
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    gpps_state_type s_q; // Registered state
    gpps_state_type s_d; // Next state
    logic [5:0] digIn; // Pin levels after the input buffers
    logic accDone; // Access phase completes at this edge
    logic wrEn; // Write takes effect
    logic rdSample; // Read data captured
    logic [7:0] mergeLvl; // Pin levels merged with written byte
    logic mapped; // Address hits a register

    // Digital input buffer per pin, off while analog is selected
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_inbuf
            assign digIn[gi] = padIn[gi] & ~s_q.ansel[gi];
        end
    endgenerate

    // Bus handshake decode
    assign accDone = psel & penable & s_q.rsp.pready;
    assign wrEn = accDone & pwrite & ~s_q.rsp.pslverr;
    assign rdSample = psel & penable & ~s_q.rsp.pready;
    assign mapped = hit(paddr, OFS_DIR) | hit(paddr, OFS_LEVEL) | hit(paddr, OFS_LATCH)
        | hit(paddr, OFS_ANSEL) | hit(paddr, OFS_ALT);

    // Current pins merged with the written byte
    always_comb begin
        mergeLvl = {2'h0, digIn};
        if (pstrb[0]) begin
            mergeLvl = pwdata[7:0];
        end
    end

    // Next-state logic
    always_comb begin
        s_d = s_q;
        // Answer one cycle into the access phase
        s_d.rsp.pready = rdSample;
        s_d.rsp.pslverr = rdSample & ~mapped;
        if (rdSample) begin
            s_d.rsp.prdata = 32'h0;
            if (hit(paddr, OFS_DIR)) begin
                s_d.rsp.prdata[5:0] = s_q.dir | DIR_FIXED;
            end
            if (hit(paddr, OFS_LEVEL)) begin
                s_d.rsp.prdata[5:0] = digIn;
            end
            if (hit(paddr, OFS_LATCH)) begin
                s_d.rsp.prdata[5:0] = s_q.lat & LAT_MASK;
            end
            if (hit(paddr, OFS_ANSEL)) begin
                s_d.rsp.prdata[5:0] = s_q.ansel & ANS_MASK;
            end
            if (hit(paddr, OFS_ALT)) begin
                s_d.rsp.prdata[7:0] = s_q.alt & ALT_MASK;
            end
        end else if (accDone) begin
            s_d.rsp.prdata = 32'h0;
        end
        // Register writes land at the completing edge
        if (wrEn) begin
            if (hit(paddr, OFS_DIR) && pstrb[0]) begin
                s_d.dir = 6'(wrMask({2'h0, s_q.dir}, pwdata[7:0], {2'h0, DIR_MASK}));
            end
            if (hit(paddr, OFS_LEVEL)) begin
                // Read-modify-write into the latch
                s_d.lat = 6'(wrMask({2'h0, s_q.lat}, mergeLvl, {2'h0, LAT_MASK}));
            end
            if (hit(paddr, OFS_LATCH) && pstrb[0]) begin
                s_d.lat = 6'(wrMask({2'h0, s_q.lat}, pwdata[7:0], {2'h0, LAT_MASK}));
            end
            if (hit(paddr, OFS_ANSEL) && pstrb[0]) begin
                s_d.ansel = 6'(wrMask({2'h0, s_q.ansel}, pwdata[7:0], {2'h0, ANS_MASK}));
            end
            if (hit(paddr, OFS_ALT) && pstrb[0]) begin
                s_d.alt = wrMask(s_q.alt, pwdata[7:0], ALT_MASK);
            end
        end
        // Plain port drive from latch and direction
        s_d.padOut = s_q.lat;
        s_d.padOe = ~(s_q.dir | DIR_FIXED);
        // Logic cell output on a2 unless steered away
        if (periph.clcEn && !s_q.alt[ALT_CLC]) begin
            s_d.padOut[PIN_2] = periph.clcOut;
            s_d.padOe[PIN_2] = 1'b1;
        end
        // Oscillator outranks serial data on a4
        if (periph.ncoEn && s_q.alt[ALT_NCO]) begin
            s_d.padOut[PIN_4] = periph.ncoOut;
            s_d.padOe[PIN_4] = 1'b1;
        end else if (periph.sdoEn && s_q.alt[ALT_SDO]) begin
            s_d.padOut[PIN_4] = periph.sdoOut;
            s_d.padOe[PIN_4] = 1'b1;
        end
        // Port C takeovers: c1, c2 with bits 0, 5 clear, c5 with bit 1 set
        s_d.pcOut = 6'h00;
        s_d.pcOvr = 6'h00;
        if (periph.ncoEn && !s_q.alt[ALT_NCO]) begin
            s_d.pcOut[PIN_1] = periph.ncoOut;
            s_d.pcOvr[PIN_1] = 1'b1;
        end
        if (periph.sdoEn && !s_q.alt[ALT_SDO]) begin
            s_d.pcOut[PIN_2] = periph.sdoOut;
            s_d.pcOvr[PIN_2] = 1'b1;
        end
        if (periph.clcEn && s_q.alt[ALT_CLC]) begin
            s_d.pcOut[PIN_5] = periph.clcOut;
            s_d.pcOvr[PIN_5] = 1'b1;
        end
        // Steered peripheral inputs
        s_d.routed.slaveSel = s_q.alt[ALT_SS] ? digIn[PIN_3] : pcIn[PIN_3];
        s_d.routed.timerGate = s_q.alt[ALT_GATE] ? digIn[PIN_3] : digIn[PIN_4];
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.dir <= DIR_RST;
            s_q.lat <= LAT_RST;
            s_q.ansel <= ANS_RST;
            s_q.alt <= ALT_RST;
            s_q.rsp <= '0;
            s_q.padOut <= 6'h00;
            s_q.padOe <= 6'h00;
            s_q.pcOut <= 6'h00;
            s_q.pcOvr <= 6'h00;
            s_q.routed <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign prdata = s_q.rsp.prdata;
    assign pready = s_q.rsp.pready;
    assign pslverr = s_q.rsp.pslverr;
    assign padOut = s_q.padOut;
    assign padOe = s_q.padOe;
    assign pcOut = s_q.pcOut;
    assign pcOvr = s_q.pcOvr;
    assign routed = s_q.routed;

endmodule
`default_nettype wire

/* tb/gpps_port_asserts.sv */
// Checker of bus timing and steered pin takeover
`default_nettype none
module gpps_port_asserts
    import gpps_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic [5:0] padOe,
    input wire logic [5:0] pcOut,
    input wire logic [5:0] pcOvr,
    input wire gpps_periph_type periph
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Waiting access phase, then a one-cycle answer
    sequence acc_s; psel && penable && !pready; endsequence
    sequence done_s; pready ##1 !pready; endsequence
    ready_wait_a: assert property (acc_s |=> done_s) else $error("bad ready");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
    err_zero_a: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper");
    pin3_in_a: assert property (!padOe[3]) else $error("pin a3 driven");
    nco_route_a: assert property (pcOvr[1] |-> $past(periph.ncoEn)
        && pcOut[1] == $past(periph.ncoOut)) else $error("osc pin");
    sdo_route_a: assert property (pcOvr[2] |-> $past(periph.sdoEn)
        && pcOut[2] == $past(periph.sdoOut)) else $error("sdo pin");
    clc_route_a: assert property (pcOvr[5] |-> $past(periph.clcEn)
        && pcOut[5] == $past(periph.clcOut)) else $error("clc pin");
    free_pins_a: assert property (pcOvr[4:3] == 2'h0 && !pcOvr[0]) else $error("pin c");
endmodule
`default_nettype wire

/* tb/gpps_pins.sv */
// Pin model resolving block drivers against outside levels
`default_nettype none
module gpps_pins (
    input wire logic [5:0] padOut,
    input wire logic [5:0] padOe,
    input wire logic [5:0] pcOut,
    input wire logic [5:0] pcOvr,
    input wire logic [5:0] extA,
    input wire logic [5:0] extC,
    output logic [5:0] padIn,
    output logic [5:0] pcIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // Driven pins show the driver, the rest the outside level
    assign padIn = (padOut & padOe) | (extA & ~padOe);
    assign pcIn = (pcOut & pcOvr) | (extC & ~pcOvr);
endmodule
`default_nettype wire

/* tb/gpps_port_tb_top.sv */
// Register, pin and steering tests of the port block
`default_nettype none
module gpps_port_tb_top;
    import gpps_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [5:0] padIn, padOut, padOe, pcIn, pcOut, pcOvr, extA = 6'h2A, extC = 6'h00;
    gpps_periph_type periph = '0;
    gpps_route_in_type routed;
    // Steering table: select value, port C takeover, driven port A levels, routed inputs
    logic [7:0] alts [7] = '{8'h3B, 8'h00, 8'h20, 8'h18, 8'h00, 8'h10, 8'h08};
    logic [5:0] ovr [3] = '{6'h20, 6'h06, 6'h02};
    logic [5:0] outs [3] = '{6'h05, 6'h11, 6'h01};
    logic [1:0] rx [7] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h0, 2'h2, 2'h1};
    int num_errors = 0, n_compared = 0, cyc = 0;
    // Clock of 20 ns period
    always #10 clk = ~clk;
    gpps_port gpps_port_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr, .padIn, .padOut, .padOe, .pcIn,
        .pcOut, .pcOvr, .periph, .routed);
    gpps_pins gpps_pins_i (.padOut, .padOe, .pcOut, .pcOvr, .extA, .extC, .padIn, .pcIn);
    // Verdict and end of run
    task automatic close_out();
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Compare one value
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
        n_compared++;
        if (got !== x) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, x, got);
        end
    endtask
    // One APB transfer, held until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read with expected data and error flag
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        chk($sformatf("read %h", a), x, q);
        chk($sformatf("error %h", a), {31'h0, xe}, {31'h0, e});
    endtask
    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_DIR, 32'h3F, 1'b0);
        rd(OFS_LATCH, 32'h0, 1'b0);
        rd(OFS_ANSEL, 32'h17, 1'b0);
        rd(OFS_LEVEL, 32'h28, 1'b0);
        apb(1'b1, OFS_ALT, 32'hFF);
        rd(OFS_ALT, 32'h3B, 1'b0);
        rd(OFS_DIR, 32'h3F, 1'b0);
        apb(1'b1, OFS_ANSEL, 32'h0);
        rd(OFS_LEVEL, 32'h2A, 1'b0);
        apb(1'b1, OFS_LATCH, 32'h3F);
        rd(OFS_LATCH, 32'h37, 1'b0);
        apb(1'b1, OFS_LEVEL, 32'h15);
        rd(OFS_LATCH, 32'h15, 1'b0);
        apb(1'b1, OFS_DIR, 32'h0);
        apb(1'b1, OFS_ANSEL, 32'h17);
        rd(OFS_DIR, 32'h08, 1'b0);
        chk("padOe", 32'h37, {26'h0, padOe});
        chk("padOut", 32'h15, {26'h0, padOut & padOe});
        rd(8'h14, 32'h0, 1'b1);
        periph <= gpps_periph_type'(6'h15);
        // Takeover rows, then routed input rows with pins as plain inputs
        for (int i = 0; i < 7; i++) begin
            if (i == 3) begin
                periph <= '0;
                extA <= 6'h08;
                apb(1'b1, OFS_ANSEL, 32'h0);
                apb(1'b1, OFS_DIR, 32'h3F);
            end
            apb(1'b1, OFS_ALT, {24'h0, alts[i]});
            repeat (2) @(posedge clk);
            if (i < 3) begin
                chk("pcOvr", {26'h0, ovr[i]}, {26'h0, pcOvr});
                chk("padOut", {26'h0, outs[i]}, {26'h0, padOut & padOe});
            end else begin
                chk("routed", {30'h0, rx[i]}, {30'h0, routed});
            end
        end
        close_out();
    end
endmodule
bind gpps_port gpps_port_asserts gpps_port_asserts_i (.clk, .rst, .psel, .penable, .pready,
    .pslverr, .prdata, .padOe, .pcOut, .pcOvr, .periph);
`default_nettype wire
